//--- tfl_pkg.sv
// constants, command codes and the numeric compare helpers for the fault logger
package tfl_pkg;

	// pmbus command codes
	localparam logic [7:0] CMD_PAGE         = 8'h00;
	localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
	localparam logic [7:0] CMD_LOG_STORE    = 8'hea;
	localparam logic [7:0] CMD_LOG_RESTORE  = 8'heb;
	localparam logic [7:0] CMD_LOG_ERASE    = 8'hec;
	localparam logic [7:0] CMD_LOG_STATUS   = 8'hed;
	localparam logic [7:0] CMD_LOG_READ     = 8'hee;
	localparam logic [7:0] PAGE_ALL         = 8'hff;
	localparam logic [7:0] READ_FILL        = 8'hff;

	// value is arbitrary, chosen for simulation only
	localparam logic [6:0] DEV_ADDR_DEF = 7'h3a;

	// fault log lock status byte
	localparam int unsigned STAT_EEPROM_BIT = 0;
	localparam int unsigned STAT_RAM_BIT    = 1;

	// record reload values
	localparam logic [15:0] VIN_PEAK_INIT  = 16'h7c00;
	localparam logic [15:0] VIN_MIN_INIT   = 16'h7bff;
	localparam logic [15:0] VOUT_PEAK_INIT = 16'hf800;
	localparam logic [15:0] VOUT_MIN_INIT  = 16'hffff;
	localparam logic [15:0] L11_PEAK_INIT  = 16'h7c00;
	localparam logic [15:0] L11_MIN_INIT   = 16'h7bff;

	// fault log layout
	localparam logic [7:0] LOG_LEN      = 8'hff;
	localparam logic [7:0] LOG_LAST     = 8'hfe;
	localparam logic [7:0] PRE_REC_BASE = 8'h0b;
	localparam logic [7:0] PRE_LEN      = 8'h2f;
	localparam logic [7:0] RING_BASE    = 8'h2f;
	localparam logic [7:0] RING_LEN     = 8'hd0;
	localparam logic [7:0] ERASED_BYTE  = 8'hff;

	// timing
	localparam int REF_CLK_NS   = 40;
	localparam int LOG_FAST_MS  = 24;
	localparam int LOG_FAST_CYC = LOG_FAST_MS * 1000000 / REF_CLK_NS;

	// five-bit exponent, eleven-bit mantissa turned into a common fixed point
	function automatic logic signed [47:0] l11_fix(input logic [15:0] v);
		logic signed [47:0] m;
		logic [4:0]         sh;
		m  = {{37{v[10]}}, v[10:0]};
		sh = {~v[15], v[14:11]};
		l11_fix = m <<< sh;
	endfunction : l11_fix

	function automatic logic num_gt(input logic [15:0] a, input logic [15:0] b,
			input logic is_l11);
		if (is_l11) begin
			num_gt = l11_fix(a) > l11_fix(b);
		end else begin
			num_gt = a > b;
		end
	endfunction : num_gt

endpackage : tfl_pkg

//--- tfl_extrema.sv
// peak and minimum record for one telemetry quantity
`timescale 1ns/1ps
`default_nettype none
module tfl_extrema #(
	parameter logic        IS_L11    = 1'b1,
	parameter logic [15:0] PEAK_INIT = 16'h0000,
	parameter logic [15:0] MIN_INIT  = 16'hffff
) (
	input  wire logic        ref_clk,  // system clock
	input  wire logic        reset_n,  // async reset, active low
	input  wire logic        clear,    // reload both records
	input  wire logic        valid,    // new conversion pulse
	input  wire logic [15:0] data,     // conversion value
	output logic      [15:0] peak_q,   // highest value seen
	output logic      [15:0] min_q     // lowest value seen
);

	logic [15:0] peak_d;
	logic [15:0] min_d;
	logic        fresh_q;
	logic        fresh_d;

	// the fresh flag makes the first conversion after reset or clear the peak, whatever value the peak reloads to
	always_comb begin
		peak_d  = peak_q;
		min_d   = min_q;
		fresh_d = fresh_q;
		if (clear) begin
			peak_d  = PEAK_INIT;
			min_d   = MIN_INIT;
			fresh_d = 1'b1;
		end else if (valid) begin
			fresh_d = 1'b0;
			if (fresh_q || tfl_pkg::num_gt(data, peak_q, IS_L11)) begin
				peak_d = data;
			end
			if (tfl_pkg::num_gt(min_q, data, IS_L11)) begin
				min_d = data;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			peak_q  <= PEAK_INIT;
			min_q   <= MIN_INIT;
			fresh_q <= 1'b1;
		end else begin
			peak_q  <= peak_d;
			min_q   <= min_d;
			fresh_q <= fresh_d;
		end
	end

endmodule : tfl_extrema
`default_nettype wire

//--- tfl_logger.sv
// telemetry extrema records and black-box fault log behind a pmbus target port
`timescale 1ns/1ps
`default_nettype none
module tfl_logger #(
	parameter int         FAST_LOG_CYC = tfl_pkg::LOG_FAST_CYC,
	parameter logic [6:0] DEV_ADDR     = tfl_pkg::DEV_ADDR_DEF
) (
	input  wire logic             ref_clk,          // 25 MHz system clock
	input  wire logic             reset_n,          // async reset, active low
	input  wire logic             scl_i,            // pmbus clock pin level
	input  wire logic             sda_i,            // pmbus data pin level
	output logic                  sda_o,            // pmbus data drive value (always low)
	output logic                  sda_oe,           // pmbus data drive enable
	input  wire logic             vin_valid,        // input voltage conversion pulse
	input  wire logic [15:0]      vin_data,         // input voltage conversion
	input  wire logic [1:0]       vout_valid,       // output voltage conversion pulses
	input  wire logic [1:0][15:0] vout_data,        // output voltage conversions
	input  wire logic [1:0]       iout_valid,       // output current conversion pulses
	input  wire logic [1:0][15:0] iout_data,        // output current conversions
	input  wire logic [1:0]       temp_valid,       // temperature measurement pulses
	input  wire logic [1:0][15:0] temp_data,        // temperature measurements
	input  wire logic [1:0]       chan_on,          // channel enabled level
	input  wire logic [1:0]       fault_off,        // channel latched off by fault
	input  wire logic             log_enable,       // fault logging enabled
	input  wire logic             all_fast,         // fast logging option
	input  wire logic             nv_eeprom_locked, // stored lock bit, caught after reset
	output logic      [7:0]       log_status_q      // copy of the lock status byte
);

	typedef enum logic [2:0] {PB_IDLE, PB_ADDR, PB_CMD, PB_WDATA, PB_READ} tfl_pb_e;
	typedef enum logic [1:0] {CP_IDLE, CP_STORE, CP_RESTORE, CP_ERASE} tfl_cp_e;

	// ---------------- pin synchronisers ----------------
	logic [2:0] scl_s_q;
	logic [2:0] sda_s_q;
	logic       scl_q;
	logic       sda_q;
	logic       scl_p_q;
	logic       sda_p_q;

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			scl_s_q <= 3'h7;
			sda_s_q <= 3'h7;
			scl_q   <= 1'b1;
			sda_q   <= 1'b1;
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_s_q <= {scl_s_q[1:0], scl_i};
			sda_s_q <= {sda_s_q[1:0], sda_i};
			if (scl_s_q[1] == scl_s_q[2]) begin
				scl_q <= scl_s_q[2];
			end
			if (sda_s_q[1] == sda_s_q[2]) begin
				sda_q <= sda_s_q[2];
			end
			scl_p_q <= scl_q;
			sda_p_q <= sda_q;
		end
	end

	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;
	assign scl_rise  = scl_q & ~scl_p_q;
	assign scl_fall  = ~scl_q & scl_p_q;
	assign bus_start = scl_q & scl_p_q & sda_p_q & ~sda_q;
	assign bus_stop  = scl_q & scl_p_q & ~sda_p_q & sda_q;

	// ---------------- shared state declarations ----------------
	logic [7:0]  ram [0:254];
	logic [7:0]  eep [0:254];
	logic        eep_bit_q;
	logic        ram_lock_q;
	tfl_cp_e     cp_q;

	// ---------------- pmbus target ----------------
	tfl_pb_e     pb_q, pb_d;
	logic [3:0]  bit_q, bit_d;
	logic [7:0]  sh_q, sh_d;
	logic [7:0]  tx_q, tx_d;
	logic [7:0]  cmd_q, cmd_d;
	logic [7:0]  wdat_q, wdat_d;
	logic [1:0]  nwr_q, nwr_d;
	logic [8:0]  ridx_q, ridx_d;
	logic        ack_q, ack_d;
	logic        nack_q, nack_d;
	logic        oe_q, oe_d;
	logic [7:0]  page_q, page_d;
	logic        store_cmd_q, store_cmd_d;
	logic        restore_cmd_q, restore_cmd_d;
	logic        erase_cmd_q, erase_cmd_d;
	logic        clear_cmd_q, clear_cmd_d;
	logic        read_done_q, read_done_d;
	logic [7:0]  tx_byte;

	always_comb begin
		case (cmd_q)
			tfl_pkg::CMD_LOG_STATUS: tx_byte = log_status_q;
			tfl_pkg::CMD_LOG_READ: begin
				if (ridx_q == 9'h000) begin
					tx_byte = tfl_pkg::LOG_LEN;
				end else begin
					tx_byte = ram[8'(ridx_q - 9'h001)];
				end
			end
			default: tx_byte = tfl_pkg::READ_FILL;
		endcase
	end

	always_comb begin
		pb_d          = pb_q;
		bit_d         = bit_q;
		sh_d          = sh_q;
		tx_d          = tx_q;
		cmd_d         = cmd_q;
		wdat_d        = wdat_q;
		nwr_d         = nwr_q;
		ridx_d        = ridx_q;
		ack_d         = ack_q;
		nack_d        = nack_q;
		oe_d          = oe_q;
		page_d        = page_q;
		store_cmd_d   = 1'b0;
		restore_cmd_d = 1'b0;
		erase_cmd_d   = 1'b0;
		clear_cmd_d   = 1'b0;
		read_done_d   = 1'b0;
		if (bus_start) begin
			pb_d  = PB_ADDR;
			bit_d = 4'h0;
			ack_d = 1'b0;
			oe_d  = 1'b0;
		end else if (bus_stop) begin
			// send-byte and write-byte commands act only once the frame is closed
			if (pb_q == PB_WDATA && nwr_q == 2'h0) begin
				store_cmd_d   = cmd_q == tfl_pkg::CMD_LOG_STORE;
				restore_cmd_d = cmd_q == tfl_pkg::CMD_LOG_RESTORE;
				erase_cmd_d   = cmd_q == tfl_pkg::CMD_LOG_ERASE;
				clear_cmd_d   = cmd_q == tfl_pkg::CMD_CLEAR_FAULTS;
			end else if (pb_q == PB_WDATA && nwr_q == 2'h1 && cmd_q == tfl_pkg::CMD_PAGE) begin
				page_d = wdat_q;
			end
			pb_d = PB_IDLE;
			oe_d = 1'b0;
		end else if (pb_q != PB_IDLE && scl_rise) begin
			if (bit_q < 4'h8) begin
				sh_d  = {sh_q[6:0], sda_q};
				bit_d = bit_q + 4'h1;
			end else begin
				bit_d  = 4'h0;
				nack_d = sda_q;
				if (pb_q == PB_READ && cmd_q == tfl_pkg::CMD_LOG_READ
						&& ridx_q == 9'h100) begin
					read_done_d = 1'b1;
				end
			end
		end else if (pb_q != PB_IDLE && scl_fall) begin
			if (ack_q) begin
				ack_d = 1'b0;
				oe_d  = 1'b0;
				if (pb_q == PB_READ) begin
					if (nack_q) begin
						pb_d = PB_IDLE;
					end else begin
						tx_d   = tx_byte;
						oe_d   = ~tx_byte[7];
						ridx_d = ridx_q + 9'h001;
					end
				end
			end else if (bit_q == 4'h8) begin
				ack_d  = 1'b1;
				nack_d = 1'b0;
				oe_d   = 1'b1;
				case (pb_q)
					PB_ADDR: begin
						if (sh_q[7:1] != DEV_ADDR) begin
							pb_d  = PB_IDLE;
							oe_d  = 1'b0;
							ack_d = 1'b0;
						end else if (sh_q[0]) begin
							pb_d   = PB_READ;
							ridx_d = 9'h000;
						end else begin
							pb_d = PB_CMD;
						end
					end
					PB_CMD: begin
						cmd_d = sh_q;
						nwr_d = 2'h0;
						pb_d  = PB_WDATA;
					end
					PB_WDATA: begin
						wdat_d = sh_q;
						if (nwr_q != 2'h3) begin
							nwr_d = nwr_q + 2'h1;
						end
					end
					PB_READ: oe_d = 1'b0;
					default: pb_d = PB_IDLE;
				endcase
			end else if (pb_q == PB_READ && bit_q != 4'h0) begin
				oe_d = ~tx_q[3'h7 - 3'(bit_q)];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			pb_q          <= PB_IDLE;
			bit_q         <= 4'h0;
			sh_q          <= 8'h00;
			tx_q          <= 8'h00;
			cmd_q         <= 8'h00;
			wdat_q        <= 8'h00;
			nwr_q         <= 2'h0;
			ridx_q        <= 9'h000;
			ack_q         <= 1'b0;
			nack_q        <= 1'b0;
			oe_q          <= 1'b0;
			page_q        <= 8'h00;
			store_cmd_q   <= 1'b0;
			restore_cmd_q <= 1'b0;
			erase_cmd_q   <= 1'b0;
			clear_cmd_q   <= 1'b0;
			read_done_q   <= 1'b0;
			sda_o         <= 1'b0;
		end else begin
			pb_q          <= pb_d;
			bit_q         <= bit_d;
			sh_q          <= sh_d;
			tx_q          <= tx_d;
			cmd_q         <= cmd_d;
			wdat_q        <= wdat_d;
			nwr_q         <= nwr_d;
			ridx_q        <= ridx_d;
			ack_q         <= ack_d;
			nack_q        <= nack_d;
			oe_q          <= oe_d;
			page_q        <= page_d;
			store_cmd_q   <= store_cmd_d;
			restore_cmd_q <= restore_cmd_d;
			erase_cmd_q   <= erase_cmd_d;
			clear_cmd_q   <= clear_cmd_d;
			read_done_q   <= read_done_d;
			sda_o         <= 1'b0;
		end
	end
	assign sda_oe = oe_q;

	// ---------------- extrema records ----------------
	logic [1:0]  on_p_q;
	logic [1:0]  flt_p_q;
	logic [1:0]  on_rise;
	logic [1:0]  clr_ch;
	logic [15:0] vin_pk;
	logic [15:0] vin_mn;
	logic [1:0][15:0] vo_pk, vo_mn, io_pk, io_mn, tp_pk, tp_mn;

	assign on_rise = chan_on & ~on_p_q;

	tfl_extrema #(.IS_L11(1'b1), .PEAK_INIT(tfl_pkg::VIN_PEAK_INIT),
			.MIN_INIT(tfl_pkg::VIN_MIN_INIT)) u_vin (
		.ref_clk(ref_clk), .reset_n(reset_n),
		.clear(clear_cmd_q | (|on_rise)),
		.valid(vin_valid), .data(vin_data), .peak_q(vin_pk), .min_q(vin_mn));

	for (genvar c = 0; c < 2; c++) begin : g_ch
		assign clr_ch[c] = (clear_cmd_q & (page_q == 8'(c) || page_q == tfl_pkg::PAGE_ALL))
				| on_rise[c];
		tfl_extrema #(.IS_L11(1'b0), .PEAK_INIT(tfl_pkg::VOUT_PEAK_INIT),
				.MIN_INIT(tfl_pkg::VOUT_MIN_INIT)) u_vout (
			.ref_clk(ref_clk), .reset_n(reset_n), .clear(clr_ch[c]),
			.valid(vout_valid[c]), .data(vout_data[c]),
			.peak_q(vo_pk[c]), .min_q(vo_mn[c]));
		tfl_extrema #(.IS_L11(1'b1), .PEAK_INIT(tfl_pkg::L11_PEAK_INIT),
				.MIN_INIT(tfl_pkg::L11_MIN_INIT)) u_iout (
			.ref_clk(ref_clk), .reset_n(reset_n), .clear(clr_ch[c]),
			.valid(iout_valid[c]), .data(iout_data[c]),
			.peak_q(io_pk[c]), .min_q(io_mn[c]));
		tfl_extrema #(.IS_L11(1'b1), .PEAK_INIT(tfl_pkg::L11_PEAK_INIT),
				.MIN_INIT(tfl_pkg::L11_MIN_INIT)) u_temp (
			.ref_clk(ref_clk), .reset_n(reset_n), .clear(clr_ch[c]),
			.valid(temp_valid[c]), .data(temp_data[c]),
			.peak_q(tp_pk[c]), .min_q(tp_mn[c]));
	end

	// ---------------- fault log ----------------
	logic [15:0] pre_w [0:17];
	always_comb begin
		pre_w[0]  = vo_pk[0];
		pre_w[1]  = vo_mn[0];
		pre_w[2]  = tp_pk[0];
		pre_w[3]  = tp_mn[0];
		pre_w[4]  = io_pk[0];
		pre_w[5]  = io_mn[0];
		pre_w[6]  = vin_pk;
		pre_w[7]  = vin_mn;
		pre_w[8]  = 16'h0000;
		pre_w[9]  = 16'h0000;
		pre_w[10] = 16'h0000;
		pre_w[11] = 16'h0000;
		pre_w[12] = vo_pk[1];
		pre_w[13] = vo_mn[1];
		pre_w[14] = tp_pk[1];
		pre_w[15] = tp_mn[1];
		pre_w[16] = io_pk[1];
		pre_w[17] = io_mn[1];
	end

	tfl_cp_e     cp_d;
	logic [7:0]  cidx_q, cidx_d;
	logic        eep_bit_d;
	logic        ram_lock_d;
	logic        boot_q, boot_d;
	logic        req_q, req_d;
	logic [5:0]  seen_q, seen_d;
	logic [19:0] wait_q, wait_d;
	logic [7:0]  walk_q, walk_d;
	logic [7:0]  pos_q, pos_d;
	logic [1:0]  pend_q, pend_d;
	logic [15:0] conv_q, conv_d;
	logic        ram_we, eep_we;
	logic [7:0]  ram_wa, eep_wa, ram_wd, eep_wd, wk_off;
	logic        refresh_ok;
	logic        conv_any;
	logic [15:0] conv_sel;
	logic        fault_ev;

	assign fault_ev = |(fault_off & ~flt_p_q);
	assign wk_off   = walk_q - tfl_pkg::PRE_REC_BASE;
	// a frozen or already saved log must not be overwritten by live data
	assign refresh_ok = (cp_q == CP_IDLE) & ~ram_lock_q & ~eep_bit_q;
	assign conv_any   = vin_valid | (|vout_valid) | (|iout_valid) | (|temp_valid);

	// at most one ring slot per three cycles: coincident conversions keep only the first listed here
	always_comb begin
		if (vin_valid)           conv_sel = vin_data;
		else if (vout_valid[0])  conv_sel = vout_data[0];
		else if (vout_valid[1])  conv_sel = vout_data[1];
		else if (iout_valid[0])  conv_sel = iout_data[0];
		else if (iout_valid[1])  conv_sel = iout_data[1];
		else if (temp_valid[0])  conv_sel = temp_data[0];
		else                     conv_sel = temp_data[1];
	end

	always_comb begin
		cp_d       = cp_q;
		cidx_d     = cidx_q;
		eep_bit_d  = eep_bit_q;
		ram_lock_d = ram_lock_q;
		boot_d     = 1'b0;
		req_d      = req_q;
		seen_d     = seen_q | {temp_valid, iout_valid, vout_valid};
		wait_d     = (wait_q != 20'h00000) ? wait_q - 20'h00001 : wait_q;
		walk_d     = walk_q;
		pos_d      = pos_q;
		pend_d     = pend_q;
		conv_d     = conv_q;
		ram_we     = 1'b0;
		ram_wa     = cidx_q;
		ram_wd     = eep[cidx_q];
		eep_we     = 1'b0;
		eep_wa     = cidx_q;
		eep_wd     = ram[cidx_q];
		if (boot_q) begin
			eep_bit_d = nv_eeprom_locked;
		end
		if ((store_cmd_q | fault_ev) & log_enable & ~eep_bit_d & ~req_q) begin
			req_d  = 1'b1;
			seen_d = 6'h00;
			wait_d = 20'(FAST_LOG_CYC);
		end
		if (read_done_q) begin
			ram_lock_d = 1'b0;
		end
		case (cp_q)
			CP_IDLE: begin
				if (erase_cmd_q) begin
					cp_d      = CP_ERASE;
					cidx_d    = 8'h00;
					eep_bit_d = 1'b0;
					// a fault that arrives with the erase is copied afterwards only if the log was not saved, as the request test sees the old lock bit
				end else if (restore_cmd_q) begin
					cp_d       = CP_RESTORE;
					cidx_d     = 8'h00;
					ram_lock_d = 1'b1;
				end else if (req_q & ((&seen_q) | (all_fast & wait_q == 20'h00000))) begin
					cp_d   = CP_STORE;
					cidx_d = 8'h00;
					req_d  = 1'b0;
				end else if (refresh_ok) begin
					if (pend_q != 2'h0) begin
						ram_we = 1'b1;
						ram_wa = tfl_pkg::RING_BASE + pos_q;
						ram_wd = (pend_q == 2'h2) ? conv_q[7:0] : conv_q[15:8];
						pend_d = pend_q - 2'h1;
						pos_d  = (pos_q == tfl_pkg::RING_LEN - 8'h01) ? 8'h00 : pos_q + 8'h01;
					end else begin
						ram_we = 1'b1;
						ram_wa = walk_q;
						if (walk_q == 8'h00) begin
							ram_wd = pos_q;
						end else if (walk_q < tfl_pkg::PRE_REC_BASE) begin
							ram_wd = 8'h00;
						end else if (wk_off[0]) begin
							ram_wd = pre_w[5'(wk_off[7:1])][15:8];
						end else begin
							ram_wd = pre_w[5'(wk_off[7:1])][7:0];
						end
						walk_d = (walk_q == tfl_pkg::PRE_LEN - 8'h01) ? 8'h00 : walk_q + 8'h01;
					end
					if (conv_any & pend_q == 2'h0) begin
						conv_d = conv_sel;
						pend_d = 2'h2;
					end
				end
			end
			CP_STORE: begin
				eep_we = 1'b1;
				cidx_d = cidx_q + 8'h01;
				if (cidx_q == tfl_pkg::LOG_LAST) begin
					cp_d      = CP_IDLE;
					eep_bit_d = 1'b1;
				end
			end
			CP_RESTORE: begin
				ram_we = 1'b1;
				cidx_d = cidx_q + 8'h01;
				if (cidx_q == tfl_pkg::LOG_LAST) begin
					cp_d = CP_IDLE;
				end
			end
			CP_ERASE: begin
				eep_we = 1'b1;
				eep_wd = tfl_pkg::ERASED_BYTE;
				cidx_d = cidx_q + 8'h01;
				if (cidx_q == tfl_pkg::LOG_LAST) begin
					cp_d = CP_IDLE;
				end
			end
			default: cp_d = CP_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			cp_q         <= CP_IDLE;
			cidx_q       <= 8'h00;
			eep_bit_q    <= 1'b0;
			ram_lock_q   <= 1'b0;
			boot_q       <= 1'b1;
			req_q        <= 1'b0;
			seen_q       <= 6'h00;
			wait_q       <= 20'h00000;
			walk_q       <= 8'h00;
			pos_q        <= 8'h00;
			pend_q       <= 2'h0;
			conv_q       <= 16'h0000;
			on_p_q       <= 2'h0;
			flt_p_q      <= 2'h0;
			log_status_q <= 8'h00;
		end else begin
			cp_q         <= cp_d;
			cidx_q       <= cidx_d;
			eep_bit_q    <= eep_bit_d;
			ram_lock_q   <= ram_lock_d;
			boot_q       <= boot_d;
			req_q        <= req_d;
			seen_q       <= seen_d;
			wait_q       <= wait_d;
			walk_q       <= walk_d;
			pos_q        <= pos_d;
			pend_q       <= pend_d;
			conv_q       <= conv_d;
			on_p_q       <= chan_on;
			flt_p_q      <= fault_off;
			log_status_q <= {6'h00, ram_lock_d, eep_bit_d};
		end
	end

	// storage arrays carry no reset
	always_ff @(posedge ref_clk) begin
		if (ram_we) begin
			ram[ram_wa] <= ram_wd;
		end
		if (eep_we) begin
			eep[eep_wa] <= eep_wd;
		end
	end

endmodule : tfl_logger
`default_nettype wire

//--- tfl_logger_assertions.sv
// lock status and pmbus checks for the fault logger
`timescale 1ns/1ps
`default_nettype none
module tfl_logger_assertions #(
	parameter int FAST_LOG_CYC = 50
) (
	input wire logic       ref_clk,     // clock
	input wire logic       reset_n,     // reset, active low
	input wire logic       scl_i,       // pmbus clock
	input wire logic       sda_oe,      // device pulls sda
	input wire logic [1:0] fault_off,   // latched off
	input wire logic       log_enable,  // logging gate
	input wire logic       all_fast,    // fast option
	input wire logic [7:0] log_status_q // lock status
);
	localparam int LIM = FAST_LOG_CYC + 300;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	property p_rsvd;
		log_status_q[7:2] == 6'h00;
	endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
	// erase acts on a stop, so clock stands high around it
	property p_ee_fell;
		$fell(log_status_q[0]) |-> scl_i && $past(scl_i, 6);
	endproperty
	a_ee_fell: assert property (p_ee_fell) else $error("lock cleared off a stop");
	property p_ram_rose;
		$rose(log_status_q[1]) |-> scl_i && $past(scl_i, 6);
	endproperty
	a_ram_rose: assert property (p_ram_rose) else $error("ram lock set off a stop");
	property p_ram_fell;
		$fell(log_status_q[1]) |-> !sda_oe;
	endproperty
	a_ram_fell: assert property (p_ram_fell) else $error("ram lock cleared mid byte");
	property p_fault;
		$rose(fault_off[0]) && log_enable && all_fast && log_status_q == 8'h00
			|-> ##[1:LIM] log_status_q[0];
	endproperty
	a_fault: assert property (p_fault) else $error("fault copy late");
	property p_ee_hold;
		$rose(log_status_q[0]) |=> log_status_q[0] [*8];
	endproperty
	a_ee_hold: assert property (p_ee_hold) else $error("eeprom lock dropped");
	property p_ee_en;
		$rose(log_status_q[0]) |-> log_enable;
	endproperty
	a_ee_en: assert property (p_ee_en) else $error("copy while disabled");
	property p_ram_hold;
		$rose(log_status_q[1]) |=> log_status_q[1] [*8];
	endproperty
	a_ram_hold: assert property (p_ram_hold) else $error("ram lock dropped");
	c_ee: cover property ($rose(log_status_q[0]));
	c_ram: cover property ($rose(log_status_q[1]));
	c_erase: cover property ($fell(log_status_q[0]));
endmodule : tfl_logger_assertions
bind tfl_logger tfl_logger_assertions #(.FAST_LOG_CYC(FAST_LOG_CYC)) tfl_logger_assertions_inst (
	.ref_clk(ref_clk), .reset_n(reset_n), .scl_i(scl_i), .sda_oe(sda_oe),
	.fault_off(fault_off), .log_enable(log_enable), .all_fast(all_fast),
	.log_status_q(log_status_q));
`default_nettype wire

//--- tfl_host.sv
// pmbus host model, bit-banged, clock stands high between frames
`timescale 1ns/1ps
`default_nettype none
module tfl_host (
	input  wire logic sda_line, // resolved data line
	output var logic  scl,      // clock
	output var logic  sda_rel   // 1 = released to pull-up
);
	logic [7:0] rx [0:255];
	int         nacks = 0;
	initial begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end
	// long low phase leaves room for the device's late ack release
	task automatic bit_io(input logic b, output logic s);
		#20 sda_rel = b;
		#180 scl = 1'b1;
		#110 s = sda_line;
		#10 scl = 1'b0;
	endtask : bit_io
	task automatic start;
		#240 sda_rel = 1'b1;
		#80 scl = 1'b1;
		#160 sda_rel = 1'b0;
		#160 scl = 1'b0;
	endtask : start
	task automatic wbyte(input logic [7:0] b);
		logic s;
		for (int j = 7; j >= 0; j--) bit_io(b[j], s);
		bit_io(1'b1, s);
		if (s !== 1'b0) nacks++;
	endtask : wbyte
	task automatic frame(input logic [7:0] cmd, input logic [7:0] dat, input int nw, input int nr);
		logic s;
		start();
		wbyte({tfl_pkg::DEV_ADDR_DEF, 1'b0});
		wbyte(cmd);
		if (nw > 0) wbyte(dat);
		if (nr > 0) begin
			start();
			wbyte({tfl_pkg::DEV_ADDR_DEF, 1'b1});
			for (int k = 0; k < nr; k++) begin
				for (int j = 7; j >= 0; j--) bit_io(1'b1, rx[k][j]);
				bit_io(k == nr - 1, s);
			end
		end
		#20 sda_rel = 1'b0;
		#140 scl = 1'b1;
		#160 sda_rel = 1'b1;
		#160;
	endtask : frame
endmodule : tfl_host
`default_nettype wire

//--- tfl_logger_tb_top.sv
// bench for the fault logger: records, log commands, lock status
`timescale 1ns/1ps
`default_nettype none
module tfl_logger_tb_top;
	typedef struct packed {logic [7:0] cmd; logic en; logic [7:0] exp;} tfl_row_s;
	localparam int FAST = 50;
	logic ref_clk, reset_n, sda_o, sda_oe, vin_valid, log_enable, all_fast, nv_lock;
	logic [15:0]      vin_data;
	logic [1:0]       vout_valid, chan_on, fault_off;
	logic [1:0][15:0] vout_data;
	logic [7:0]       log_status_q;
	wire logic        scl, sda_rel, sda_line;
	int               mismatches = 0;
	int               compares = 0;
	// refused store, store, second store ignored, restore
	tfl_row_s rows [4] = '{'{8'hea, 1'b0, 8'h00}, '{8'hea, 1'b1, 8'h01},
		'{8'hea, 1'b1, 8'h01}, '{8'heb, 1'b1, 8'h03}};
	assign sda_line = sda_rel & ~(sda_oe & ~sda_o);
	tfl_host tfl_host_inst (.sda_line(sda_line), .scl(scl), .sda_rel(sda_rel));
	tfl_logger #(.FAST_LOG_CYC(FAST)) tfl_logger_inst (
		.ref_clk(ref_clk), .reset_n(reset_n), .scl_i(scl), .sda_i(sda_line),
		.sda_o(sda_o), .sda_oe(sda_oe), .vin_valid(vin_valid), .vin_data(vin_data),
		.vout_valid(vout_valid), .vout_data(vout_data),
		// current and temperature ride on the voltage stimulus but compare as L11
		.iout_valid(vout_valid), .iout_data(vout_data),
		.temp_valid(vout_valid), .temp_data(vout_data), .chan_on(chan_on), .fault_off(fault_off),
		.log_enable(log_enable), .all_fast(all_fast), .nv_eeprom_locked(nv_lock),
		.log_status_q(log_status_q));
	task automatic results;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : results
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
		compares++;
		if (s !== e) begin
			mismatches++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask : chk
	task automatic rec(input string n, input int off, input logic [15:0] e);
		chk(n, e, {tfl_host_inst.rx[off + 2], tfl_host_inst.rx[off + 1]});
	endtask : rec
	task automatic conv(input logic [15:0] v, input logic [15:0] o0, input logic [15:0] o1);
		@(negedge ref_clk);
		vin_data = v;
		vout_data = {o1, o0};
		{vin_valid, vout_valid} = 3'h7;
		@(negedge ref_clk);
		{vin_valid, vout_valid} = 3'h0;
	endtask : conv
	task automatic stat(input string n, input logic [7:0] e);
		repeat (FAST + 300) @(negedge ref_clk);
		chk(n, {8'h00, e}, {8'h00, log_status_q});
	endtask : stat
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	initial begin
		{reset_n, vin_valid, vin_data, vout_valid, vout_data, chan_on, fault_off, nv_lock} = '0;
		{log_enable, all_fast} = 2'b11;
		repeat (5) @(negedge ref_clk);
		chk("rst", 16'h0000, {6'h00, sda_o, sda_oe, log_status_q});
		reset_n = 1'b1;
		// f808 is numerically smallest though largest unsigned
		conv(16'h0010, 16'h1234, 16'h0200);
		chan_on = 2'b10;
		conv(16'h0020, 16'h0100, 16'h0300);
		conv(16'hf808, 16'h0800, 16'h0250);
		tfl_host_inst.frame(tfl_pkg::CMD_LOG_READ, 8'h00, 0, 256);
		chk("count", 16'h00ff, {8'h00, tfl_host_inst.rx[0]});
		rec("vin pk", 23, 16'h0020);
		rec("vin mn", 25, 16'hf808);
		rec("vout0 pk", 11, 16'h1234);
		rec("vout0 mn", 13, 16'h0100);
		rec("temp0 pk", 15, 16'h1234);
		rec("iout0 mn", 21, 16'h0800);
		tfl_host_inst.frame(tfl_pkg::CMD_PAGE, 8'h00, 1, 0);
		tfl_host_inst.frame(tfl_pkg::CMD_CLEAR_FAULTS, 8'h00, 0, 0);
		tfl_host_inst.frame(tfl_pkg::CMD_LOG_READ, 8'h00, 0, 256);
		rec("vin pk", 23, 16'h7c00);
		rec("vin mn", 25, 16'h7bff);
		rec("vout0 pk", 11, 16'hf800);
		rec("vout0 mn", 13, 16'hffff);
		rec("temp0 mn", 17, 16'h7bff);
		rec("iout0 pk", 19, 16'h7c00);
		rec("vout1 pk", 35, 16'h0300);
		rec("vout1 mn", 37, 16'h0250);
		foreach (rows[i]) begin
			@(negedge ref_clk);
			log_enable = rows[i].en;
			tfl_host_inst.frame(rows[i].cmd, 8'h00, 0, 0);
			stat("status", rows[i].exp);
			tfl_host_inst.frame(tfl_pkg::CMD_LOG_STATUS, 8'h00, 0, 1);
			chk("status rd", {8'h00, rows[i].exp}, {8'h00, tfl_host_inst.rx[0]});
		end
		tfl_host_inst.frame(tfl_pkg::CMD_LOG_READ, 8'h00, 0, 256);
		chk("unlock", 16'h0001, {8'h00, log_status_q});
		tfl_host_inst.frame(tfl_pkg::CMD_LOG_STATUS, 8'h00, 0, 1);
		chk("ram lock", 16'h0000, {15'h0000, tfl_host_inst.rx[0][1]});
		tfl_host_inst.frame(tfl_pkg::CMD_LOG_ERASE, 8'h00, 0, 0);
		stat("erase", 8'h00);
		fault_off = 2'b01;
		stat("fault", 8'h01);
		{fault_off, all_fast} = 3'b000;
		tfl_host_inst.frame(tfl_pkg::CMD_LOG_ERASE, 8'h00, 0, 0);
		stat("erase", 8'h00);
		fault_off = 2'b01;
		stat("slow wait", 8'h00);
		conv(16'h0010, 16'h0100, 16'h0100);
		stat("slow copy", 8'h01);
		nv_lock = 1'b1;
		reset_n = 1'b0;
		repeat (5) @(negedge ref_clk);
		reset_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		chk("kept", 16'h0001, {8'h00, log_status_q});
		chk("nacks", 16'h0000, tfl_host_inst.nacks[15:0]);
		results();
	end
endmodule : tfl_logger_tb_top
`default_nettype wire
